// file: core/eit_top.sv
// Notes on behaviour
// [RULE1] start and stop edges: rise-fall, fall-rise or rise-rise.
// [RULE2] software must never select falling start with falling stop.
// [RULE3] range setting fixes the longest measurable interval.
// [RULE4] an interval beyond the range reads as the full-scale value.
// [RULE5] lsb is 31.25 ns at 1 ms range, doubling per range doubling.
// [RULE6] a sample without a finished interval repeats the last result.
// [RULE7] before any finished interval every sample reads zero.
// [RULE8] several intervals in one sample: only the latest is reported.
// [RULE9] pulse-time gives delay from last pulse edge to sample instant.
// [RULE10] pulse-time only with sample interval at most 1 ms, or 100 us hi-res.
// [RULE11] frequency mode gives an unsigned value, no direction sensing.
// [RULE12] speed mode converts pulses to metres per second via pulses per metre.
// [RULE13] rpm mode converts pulses to rev per minute via pulses per revolution.
// [RULE14] duty ratio is user scaling of high time by known frequency.
// [RULE15] counter clears on start, counts ticks while armed, latches on stop.
//
// Our own choices: the APB interface to the registers and the register addresses.
module eit_top #(
  parameter bit HIRES = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [eit_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // thresholded sensor pin
  input wire logic pulse_i,
  // sampled result stream
  output logic [31:0] result_o,
  output logic sample_o
);
  typedef struct packed {
    logic en;
    eit_pkg::eit_edge_t edge_sel;
    logic [eit_pkg::RANGE_W-1:0] range;
    eit_pkg::eit_mode_t mode;
    logic [31:0] period;
    logic [eit_pkg::PPU_W-1:0] ppu;
    logic [31:0] scnt;
    logic [31:0] result;
    logic strobe;
    logic [31:0] nsamp;
    logic [31:0] rdata;
    logic slverr;
    logic ready;
    logic ovr_seen;
    logic [15:0] evcnt;
    logic seen;
    logic [31:0] span_run;
    logic [31:0] span_last;
    eit_pkg::eit_div_t div;
    logic [63:0] dnum;
    logic [47:0] dden;
    logic [47:0] drem;
    logic [31:0] dq;
    logic dovf;
    logic [6:0] dcnt;
    logic [31:0] freq;
  } eit_top_st_t;

  eit_top_st_t s_q;
  eit_top_st_t s_d;
  eit_meas_if mi();
  logic pt_ok;
  logic sample;
  logic div_go;
  logic combined;
  logic [eit_pkg::PPU_W-1:0] ppu_eff;
  logic [63:0] num_scale;
  logic [48:0] trial;
  logic [31:0] q_next;

  eit_meas u_meas (
    .pclk(pclk),
    .presetn(presetn),
    .pulse_i(pulse_i),
    .mi(mi)
  );

  assign mi.enable = s_q.en;
  assign mi.edge_sel = s_q.edge_sel;
  assign mi.range = s_q.range;

  always_comb begin
    s_d = s_q;
    s_d.ready = 1'b1;
    s_d.strobe = 1'b0;
    // [RULE10] pulse-time gated by sample interval
    pt_ok = s_q.period <= (HIRES ? eit_pkg::PT_MAX_HR_CYC : eit_pkg::PT_MAX_STD_CYC);
    combined = (s_q.mode == eit_pkg::MODE_FREQ) || (s_q.mode == eit_pkg::MODE_SPEED) ||
               (s_q.mode == eit_pkg::MODE_RPM);
    ppu_eff = (s_q.mode == eit_pkg::MODE_FREQ || s_q.ppu == '0) ? 16'h0001 : s_q.ppu;
    num_scale = (s_q.mode == eit_pkg::MODE_RPM) ? 64'(eit_pkg::RPM_SCALE) : 64'h1;
    sample = 1'b0;
    div_go = 1'b0;
    trial = '0;
    q_next = '0;

    // register read data is prepared in the setup phase
    if (psel && !penable) begin
      s_d.rdata = '0;
      s_d.slverr = 1'b0;
      case (paddr)
        eit_pkg::REG_CTRL: begin
          s_d.rdata = (32'(s_q.en) << eit_pkg::CTRL_EN) |
                      (32'(s_q.edge_sel) << eit_pkg::CTRL_EDGE_LSB) |
                      (32'(s_q.range) << eit_pkg::CTRL_RANGE_LSB) |
                      (32'(s_q.mode) << eit_pkg::CTRL_MODE_LSB);
        end
        eit_pkg::REG_PERIOD: s_d.rdata = s_q.period;
        eit_pkg::REG_PPU: s_d.rdata = 32'(s_q.ppu);
        eit_pkg::REG_RESULT: s_d.rdata = s_q.result;
        eit_pkg::REG_STATUS: begin
          s_d.rdata = (32'(mi.ever_valid) << eit_pkg::ST_EVER) |
                      (32'(pt_ok) << eit_pkg::ST_PT_OK) |
                      (32'(s_q.ovr_seen) << eit_pkg::ST_OVR) |
                      (32'(s_q.edge_sel == eit_pkg::EDGE_FALL_FALL) << eit_pkg::ST_BAD_EDGE);
        end
        eit_pkg::REG_COUNT: s_d.rdata = s_q.nsamp;
        default: s_d.slverr = 1'b1;
      endcase
    end
    if (psel && penable && pwrite) begin
      case (paddr)
        eit_pkg::REG_CTRL: begin
          s_d.en = pwdata[eit_pkg::CTRL_EN];
          s_d.edge_sel = eit_pkg::eit_edge_t'(pwdata[eit_pkg::CTRL_EDGE_LSB +: 2]);
          s_d.range = pwdata[eit_pkg::CTRL_RANGE_LSB +: eit_pkg::RANGE_W];
          s_d.mode = eit_pkg::eit_mode_t'(pwdata[eit_pkg::CTRL_MODE_LSB +: 3]);
        end
        eit_pkg::REG_PERIOD: s_d.period = pwdata;
        eit_pkg::REG_PPU: s_d.ppu = pwdata[eit_pkg::PPU_W-1:0];
        default: begin
        end
      endcase
    end

    // combined measurement: edges and span from first to last edge
    if (s_q.seen) s_d.span_run = s_q.span_run + 32'h1;
    if (mi.rise) begin
      if (!s_q.seen) begin
        s_d.seen = 1'b1;
        s_d.span_run = '0;
        s_d.evcnt = 16'h1;
      end else begin
        s_d.evcnt = (&s_q.evcnt) ? s_q.evcnt : s_q.evcnt + 16'h1;
        s_d.span_last = s_q.span_run + 32'h1;
      end
    end

    // sampling instant
    if (s_q.en && s_q.period != '0) begin
      if (s_q.scnt >= s_q.period - 32'h1) begin
        sample = 1'b1;
        s_d.scnt = '0;
      end else begin
        s_d.scnt = s_q.scnt + 32'h1;
      end
    end else begin
      s_d.scnt = '0;
    end

    if (sample) begin
      s_d.strobe = 1'b1;
      s_d.nsamp = s_q.nsamp + 32'h1;
      s_d.ovr_seen = mi.overrange;
      case (s_q.mode)
        // [RULE6] [RULE7] last interval held, zero before any
        eit_pkg::MODE_TIME: s_d.result = 32'(mi.last_time);
        // [RULE9] edge-to-sample delay in clock cycles
        eit_pkg::MODE_PULSE_TIME: s_d.result = pt_ok ? mi.pulse_age : '0;
        // [RULE11] unsigned quotient held between updates
        eit_pkg::MODE_FREQ, eit_pkg::MODE_SPEED, eit_pkg::MODE_RPM: s_d.result = s_q.freq;
        default: s_d.result = '0;
      endcase
      div_go = combined && s_q.evcnt >= 16'h2 && s_q.div == eit_pkg::DIV_IDLE;
      // an edge on the sample cycle opens the next interval
      s_d.seen = mi.rise;
      s_d.evcnt = mi.rise ? 16'h1 : 16'h0;
      s_d.span_run = '0;
    end

    // [RULE12] [RULE13] scale by pulses per unit and 60 for rpm
    if (div_go) begin
      s_d.div = eit_pkg::DIV_RUN;
      s_d.dnum = (64'(s_q.evcnt - 16'h1) * 64'(eit_pkg::CLK_HZ) * num_scale) << eit_pkg::FRAC_W;
      s_d.dden = 48'(s_q.span_last) * 48'(ppu_eff);
      s_d.drem = '0;
      s_d.dq = '0;
      s_d.dovf = 1'b0;
      s_d.dcnt = eit_pkg::DIV_LAST;
    end else if (s_q.div == eit_pkg::DIV_RUN) begin
      // one quotient bit per clock keeps the datapath to a single subtractor
      trial = {s_q.drem, s_q.dnum[63]};
      s_d.dnum = {s_q.dnum[62:0], 1'b0};
      if (trial >= {1'b0, s_q.dden}) begin
        s_d.drem = 48'(trial - {1'b0, s_q.dden});
        q_next = {s_q.dq[30:0], 1'b1};
      end else begin
        s_d.drem = trial[47:0];
        q_next = {s_q.dq[30:0], 1'b0};
      end
      s_d.dq = q_next;
      s_d.dovf = s_q.dovf | s_q.dq[31];
      if (s_q.dcnt == '0) begin
        s_d.div = eit_pkg::DIV_IDLE;
        s_d.freq = (s_q.dovf | s_q.dq[31]) ? '1 : q_next;
      end else begin
        s_d.dcnt = s_q.dcnt - 7'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.period <= eit_pkg::PERIOD_RST;
      s_q.ppu <= eit_pkg::PPU_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.slverr;
  assign result_o = s_q.result;
  assign sample_o = s_q.strobe;

  a_zero_before: assert property (@(posedge pclk) disable iff (!presetn) // [RULE7]
    s_q.strobe && $past(s_q.mode) == eit_pkg::MODE_TIME && !$past(mi.ever_valid)
      |-> s_q.result == '0)
    else $error("nonzero result before any interval");
  a_hold_last: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    s_q.strobe && $past(s_q.mode) == eit_pkg::MODE_TIME |-> s_q.result == 32'($past(mi.last_time)))
    else $error("time result is not the latest interval");
  a_pt_gated: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
    s_q.strobe && $past(s_q.mode) == eit_pkg::MODE_PULSE_TIME && !$past(pt_ok)
      |-> s_q.result == '0)
    else $error("pulse time given with too long sample interval");
  a_pt_value: assert property (@(posedge pclk) disable iff (!presetn) // [RULE9]
    s_q.strobe && $past(s_q.mode) == eit_pkg::MODE_PULSE_TIME && $past(pt_ok)
      |-> s_q.result == $past(mi.pulse_age))
    else $error("pulse time differs from edge age");
  a_div_length: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
    $rose(s_q.div == eit_pkg::DIV_RUN) |-> ##63 s_q.div == eit_pkg::DIV_RUN ##1 s_q.div == eit_pkg::DIV_IDLE)
    else $error("conversion did not take 64 cycles");
  a_rpm_scale: assert property (@(posedge pclk) disable iff (!presetn) // [RULE13]
    div_go && s_q.mode == eit_pkg::MODE_RPM |=> (s_q.dnum % 64'(eit_pkg::RPM_SCALE)) == 64'h0)
    else $error("rpm numerator not scaled by sixty");

  // conversion steps: start, 64 busy cycles, idle again
  sequence s_div_begin;
    div_go;
  endsequence
  sequence s_div_busy;
    s_q.div == eit_pkg::DIV_RUN;
  endsequence
  sequence s_div_done;
    s_q.div == eit_pkg::DIV_IDLE;
  endsequence
  a_div_steps: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
    s_div_begin |=> s_div_busy ##63 s_div_busy ##1 s_div_done)
    else $error("conversion steps out of order");

  a_result_held: assert property (@(posedge pclk) disable iff (!presetn) // [RULE6]
    !s_q.strobe |-> s_q.result == $past(s_q.result))
    else $error("result changed between samples");
  a_ovr_status: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
    s_q.strobe |-> s_q.ovr_seen == $past(mi.overrange))
    else $error("overrange status not taken at sample");

  // one strobe per sampling instant
  a_strobe_single: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.strobe && s_q.period > 32'h1 |=> !s_q.strobe)
    else $error("sample strobe longer than one cycle");
  a_count_step: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.strobe |-> s_q.nsamp == $past(s_q.nsamp) + 32'h1)
    else $error("sample count did not step");

  // register bus: refusals and writes
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable && paddr > eit_pkg::REG_COUNT |=> s_q.slverr && s_q.rdata == '0)
    else $error("unmapped address not refused");
  a_period_write: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && paddr == eit_pkg::REG_PERIOD
      |=> s_q.period == $past(pwdata))
    else $error("period write did not land");
  a_ppu_write: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && paddr == eit_pkg::REG_PPU
      |=> s_q.ppu == $past(pwdata[eit_pkg::PPU_W-1:0]))
    else $error("pulses per unit write did not land");
  a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && paddr == eit_pkg::REG_CTRL
      |=> s_q.en == $past(pwdata[eit_pkg::CTRL_EN]))
    else $error("control write did not land");
  a_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
    $past(presetn) |-> s_q.ready)
    else $error("ready low outside reset");
endmodule

// file: core/eit_pkg.sv
package eit_pkg;
  // clock and timing
  localparam int CLK_HZ = 50_000_000;
  localparam int CLK_PS = 20_000;
  // finest interval resolution, 31.25 ns
  localparam int RES0_PS = 31_250;
  localparam int ACC_W = 24;
  localparam logic [63:0] TICK_INC0_W = (64'h1 << ACC_W) * 64'(CLK_PS) / 64'(RES0_PS);
  localparam logic [ACC_W-1:0] TICK_INC0 = TICK_INC0_W[ACC_W-1:0];

  // interval counter and full-scale values
  localparam int CNT_W = 16;
  localparam int RANGE_W = 4;
  localparam logic [RANGE_W-1:0] RANGE_16MS = 4'h4;
  localparam logic [RANGE_W-1:0] RANGE_120MS = 4'h7;
  localparam logic [RANGE_W-1:0] RANGE_16S = 4'hE;
  localparam logic [CNT_W-1:0] FS_32000 = 16'h7D00;
  localparam logic [CNT_W-1:0] FS_30000 = 16'h7530;
  localparam logic [CNT_W-1:0] FS_31250 = 16'h7A12;
  localparam logic [CNT_W-1:0] FS_29296 = 16'h7270;

  function automatic logic [CNT_W-1:0] full_scale(input logic [RANGE_W-1:0] r);
    if (r <= RANGE_16MS) return FS_32000;
    else if (r <= RANGE_120MS) return FS_30000;
    else if (r <= RANGE_16S) return FS_31250;
    else return FS_29296;
  endfunction

  // pulse-time availability limits on the sampling interval
  localparam int PT_MAX_STD_US = 1000;
  localparam int PT_MAX_HR_US = 100;
  localparam logic [31:0] PT_MAX_STD_CYC = 32'(PT_MAX_STD_US * (CLK_HZ / 1_000_000));
  localparam logic [31:0] PT_MAX_HR_CYC = 32'(PT_MAX_HR_US * (CLK_HZ / 1_000_000));

  // combined measurement arithmetic
  localparam int RPM_SCALE = 60;
  localparam int FRAC_W = 16;
  localparam int PPU_W = 16;
  localparam logic [6:0] DIV_LAST = 7'h3F;

  // register map
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_PERIOD = 8'h04;
  localparam logic [ADDR_W-1:0] REG_PPU = 8'h08;
  localparam logic [ADDR_W-1:0] REG_RESULT = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_STATUS = 8'h10;
  localparam logic [ADDR_W-1:0] REG_COUNT = 8'h14;
  localparam int CTRL_EN = 0;
  localparam int CTRL_EDGE_LSB = 1;
  localparam int CTRL_RANGE_LSB = 3;
  localparam int CTRL_MODE_LSB = 8;
  localparam int ST_EVER = 0;
  localparam int ST_PT_OK = 1;
  localparam int ST_OVR = 2;
  localparam int ST_BAD_EDGE = 3;
  localparam logic [31:0] PERIOD_RST = 32'h0000_0000;
  localparam logic [PPU_W-1:0] PPU_RST = 16'h0001;

  typedef enum logic [1:0] {EDGE_RISE_FALL, EDGE_FALL_RISE, EDGE_RISE_RISE, EDGE_FALL_FALL} eit_edge_t;
  typedef enum logic [2:0] {MODE_TIME, MODE_PULSE_TIME, MODE_FREQ, MODE_SPEED, MODE_RPM} eit_mode_t;
  typedef enum logic {DIV_IDLE, DIV_RUN} eit_div_t;
endpackage

// file: core/eit_meas_if.sv
interface eit_meas_if;
  logic enable;
  eit_pkg::eit_edge_t edge_sel;
  logic [eit_pkg::RANGE_W-1:0] range;
  logic [eit_pkg::CNT_W-1:0] last_time;
  logic ever_valid;
  logic overrange;
  logic [31:0] pulse_age;
  logic rise;
  modport ctl (output enable, edge_sel, range,
               input last_time, ever_valid, overrange, pulse_age, rise);
  modport meas (input enable, edge_sel, range,
                output last_time, ever_valid, overrange, pulse_age, rise);
endinterface

// file: core/eit_meas.sv
module eit_meas (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // thresholded sensor level, asynchronous
  input wire logic pulse_i,
  // configuration and results
  eit_meas_if.meas mi
);
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
    logic [eit_pkg::ACC_W-1:0] acc;
    logic armed;
    logic over;
    logic [eit_pkg::CNT_W-1:0] cnt;
    logic [eit_pkg::CNT_W-1:0] last;
    logic ever;
    logic ovr;
    logic [31:0] age;
    logic rise;
  } eit_meas_st_t;

  eit_meas_st_t s_q;
  eit_meas_st_t s_d;
  logic [eit_pkg::ACC_W:0] acc_sum;
  logic tick;
  logic rise;
  logic fall;
  logic start;
  logic stop;
  logic [eit_pkg::CNT_W-1:0] fs;

  always_comb begin
    s_d = s_q;
    s_d.sync1 = pulse_i;
    s_d.sync2 = s_q.sync1;
    s_d.prev = s_q.sync2;
    rise = s_q.sync2 & ~s_q.prev;
    fall = ~s_q.sync2 & s_q.prev;
    // [RULE5] resolution tick rate halves per range step, so the lsb doubles
    acc_sum = {1'b0, s_q.acc} + {1'b0, eit_pkg::TICK_INC0 >> mi.range};
    tick = acc_sum[eit_pkg::ACC_W];
    s_d.acc = acc_sum[eit_pkg::ACC_W-1:0];
    // [RULE3] range sets full scale
    fs = eit_pkg::full_scale(mi.range);
    // [RULE1] edge pairing select
    case (mi.edge_sel)
      eit_pkg::EDGE_RISE_FALL: begin
        start = rise;
        stop = fall;
      end
      eit_pkg::EDGE_FALL_RISE: begin
        start = fall;
        stop = rise;
      end
      eit_pkg::EDGE_RISE_RISE: begin
        start = rise;
        stop = rise;
      end
      // [RULE2] illegal pairing measures nothing
      default: begin
        start = 1'b0;
        stop = 1'b0;
      end
    endcase
    s_d.rise = rise;
    // [RULE9] cycles since last rising edge
    s_d.age = rise ? '0 : ((&s_q.age) ? s_q.age : s_q.age + 32'h1);
    if (!mi.enable) begin
      s_d.armed = 1'b0;
      s_d.cnt = '0;
    end else begin
      // [RULE15] count ticks while armed
      if (s_q.armed && tick) begin
        if (s_q.cnt < fs) s_d.cnt = s_q.cnt + 16'h1;
        else s_d.over = 1'b1;
      end
      // [RULE8] later stop overwrites result
      // [RULE4] clamp to full scale on latch
      if (stop && s_q.armed) begin
        s_d.last = (s_d.cnt > fs) ? fs : s_d.cnt;
        s_d.ever = 1'b1;
        s_d.ovr = s_d.over;
        s_d.armed = 1'b0;
      end
      // stop before start so rise-to-rise restarts at once
      if (start) begin
        s_d.armed = 1'b1;
        s_d.cnt = '0;
        s_d.over = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) s_q <= '0;
    else s_q <= s_d;
  end

  assign mi.last_time = s_q.last;
  assign mi.ever_valid = s_q.ever;
  assign mi.overrange = s_q.ovr;
  assign mi.pulse_age = s_q.age;
  assign mi.rise = s_q.rise;

  a_clamp_full: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
    mi.enable && stop && s_q.armed |=> s_q.last <= $past(fs))
    else $error("latched interval above full scale");
  a_start_clears: assert property (@(posedge pclk) disable iff (!presetn) // [RULE15]
    mi.enable && start |=> s_q.armed && s_q.cnt == '0)
    else $error("start edge did not clear counter");
  a_stop_latches: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    mi.enable && stop && s_q.armed && !start |=> !s_q.armed && s_q.ever)
    else $error("stop edge did not latch interval");
  a_edge_pairing: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    mi.enable && s_q.armed && rise && mi.edge_sel == eit_pkg::EDGE_FALL_RISE |=> !s_q.armed)
    else $error("rising edge did not stop fall-to-rise interval");
  a_tick_rate: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    tick && mi.range != '0 |=> !tick)
    else $error("resolution tick too fast for range");
endmodule

// file: tb/eit_pulse_model.sv
module eit_pulse_model (
  // clock
  input wire logic pclk,
  // waveform shape, in pclk cycles
  input wire logic run,
  input wire logic [31:0] high_cyc,
  input wire logic [31:0] low_cyc,
  // thresholded sensor level
  output logic pulse_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [31:0] cnt_q;

  initial begin
    pulse_o = 1'b0;
    cnt_q = 32'h0;
  end

  // a stopped sensor parks low, so only a falling edge can follow a stop
  always @(posedge pclk) begin
    if (!run) begin
      pulse_o <= 1'b0;
      cnt_q <= 32'h0;
    end else if (cnt_q + 32'h1 >= (pulse_o ? high_cyc : low_cyc)) begin
      pulse_o <= !pulse_o;
      cnt_q <= 32'h0;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule

// file: tb/test_edge_interval_timer.sv
module test_edge_interval_timer;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pulse_i, sample_o, run, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, result_o, hc, lc, r, s1;
  logic [31:0] fx [3];
  int num_errors, checks, i;

  eit_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pulse_i(pulse_i), .result_o(result_o), .sample_o(sample_o));
  eit_pulse_model u_src (.pclk(pclk), .run(run), .high_cyc(hc), .low_cyc(lc),
    .pulse_o(pulse_i));

  initial pclk = 1'b0;
  always #10 pclk = ~pclk;

  task automatic finish_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // tick phase jitters by a clock, so counts get a tolerance
  task automatic check_near(input logic [31:0] got, input logic [31:0] exp,
                            input logic [31:0] tol);
    checks++;
    if ($isunknown(got) || got + tol < exp || got > exp + tol) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h near %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      num_errors++;
      finish_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    check_eq(r & m, exp);
  endtask

  task automatic wait_sample;
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sample_o !== 1'b1 && n < 60000);
    if (sample_o !== 1'b1) begin
      num_errors++;
      finish_test();
    end
  endtask

  // stop the sensor just after a fall, so the stop itself makes no edge
  task automatic park;
    int n;
    n = 0;
    while (pulse_i !== 1'b1 && n < 60000) begin
      @(posedge pclk);
      n++;
    end
    while (pulse_i !== 1'b0 && n < 60000) begin
      @(posedge pclk);
      n++;
    end
    run <= 1'b0;
    if (pulse_i !== 1'b0 || n >= 60000) begin
      num_errors++;
      finish_test();
    end
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] ed, input logic [3:0] rg,
                                      input logic [2:0] md);
    return 32'h1 | (32'(ed) << eit_pkg::CTRL_EDGE_LSB) |
      (32'(rg) << eit_pkg::CTRL_RANGE_LSB) | (32'(md) << eit_pkg::CTRL_MODE_LSB);
  endfunction

  initial begin
    {psel, penable, pwrite, run} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    hc = 32'hFA;
    lc = 32'h1F4;
    // 800-cycle pulse period: 62500 Hz, speed and rpm with 100 pulses per unit
    fx = '{32'hF424_0000, 32'h0271_0000, 32'h927C_0000};
    num_errors = 0;
    checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rd(eit_pkg::REG_CTRL, 32'h0, 32'hFFFF_FFFF);
    rd(eit_pkg::REG_PERIOD, eit_pkg::PERIOD_RST, 32'hFFFF_FFFF);
    rd(eit_pkg::REG_PPU, 32'(eit_pkg::PPU_RST), 32'h0000_FFFF);
    // a zero period is within the pulse-time limit
    rd(eit_pkg::REG_STATUS, 32'h2, 32'h0000_000F);
    apb(1'b0, 8'hFC, 32'h0);
    check_eq({31'h0, e}, 32'h1);
    wr(eit_pkg::REG_PERIOD, 32'h3E8);
    wr(eit_pkg::REG_CTRL, ctl(2'h0, eit_pkg::RANGE_16MS, eit_pkg::MODE_TIME));
    repeat (2) wait_sample;
    check_eq(result_o, 32'h0);
    run <= 1'b1;
    // 500 ns ticks are 25 clocks: 250, 500 and 750 clocks give 10, 20, 30
    for (i = 0; i < 3; i++) begin
      wr(eit_pkg::REG_CTRL, ctl(2'(i), eit_pkg::RANGE_16MS, eit_pkg::MODE_TIME));
      repeat (3) wait_sample;
      check_near(result_o, 32'(i + 1) * 32'hA, 32'h1);
    end
    run <= 1'b0;
    wait_sample;
    s1 = result_o;
    repeat (2) wait_sample;
    check_eq(result_o, s1);
    rd(eit_pkg::REG_STATUS, 32'h1, 32'h1);
    hc <= 32'h3E8;
    wr(eit_pkg::REG_CTRL, ctl(2'h0, 4'h0, eit_pkg::MODE_TIME));
    run <= 1'b1;
    repeat (4) wait_sample;
    check_near(result_o, 32'h280, 32'h1);
    // a fall while high would latch a short interval
    park;
    hc <= 32'hC3B4;
    wr(eit_pkg::REG_PERIOD, 32'h7D0);
    run <= 1'b1;
    repeat (20) wait_sample;
    check_near(result_o, 32'h280, 32'h1);
    repeat (7) wait_sample;
    check_eq(result_o, 32'(eit_pkg::FS_32000));
    rd(eit_pkg::REG_STATUS, 32'h4, 32'h4);
    rd(eit_pkg::REG_RESULT, 32'(eit_pkg::FS_32000), 32'hFFFF_FFFF);
    run <= 1'b0;
    wr(eit_pkg::REG_CTRL, ctl(2'h3, 4'h0, eit_pkg::MODE_TIME));
    rd(eit_pkg::REG_STATUS, 32'h8, 32'h8);
    wr(eit_pkg::REG_PERIOD, 32'hC350);
    rd(eit_pkg::REG_STATUS, 32'h2, 32'h2);
    wr(eit_pkg::REG_PERIOD, 32'hC351);
    rd(eit_pkg::REG_STATUS, 32'h0, 32'h2);
    // pulse period divides the sample period, so the age repeats
    hc <= 32'hC8;
    lc <= 32'h12C;
    wr(eit_pkg::REG_PERIOD, 32'h3E8);
    wr(eit_pkg::REG_CTRL, ctl(2'h0, 4'h0, eit_pkg::MODE_PULSE_TIME));
    run <= 1'b1;
    repeat (3) wait_sample;
    s1 = result_o;
    check_near(s1, 32'hFA, 32'hFA);
    wait_sample;
    check_eq(result_o, s1);
    run <= 1'b0;
    repeat (2) wait_sample;
    s1 = result_o;
    wait_sample;
    check_eq(result_o, s1 + 32'h3E8);
    hc <= 32'h190;
    lc <= 32'h190;
    wr(eit_pkg::REG_PPU, 32'h64);
    wr(eit_pkg::REG_PERIOD, 32'h960);
    run <= 1'b1;
    // divider result trails by one sample, hence the extra waits
    for (i = 0; i < 3; i++) begin
      wr(eit_pkg::REG_CTRL, ctl(2'h0, 4'h0, 3'(i) + eit_pkg::MODE_FREQ));
      repeat (3) wait_sample;
      check_near(result_o, fx[i], 32'h1);
    end
    finish_test();
  end
endmodule
